// *** rtl/adc_pkg.sv ***
/*
 Shared constants and types for the single-conversion converter control.
 Assumes a 32-bit register bus with byte addresses in the low eight bits.
*/
package adc_pkg;
   // Register byte offsets
   localparam logic [7:0] CTRL_A_OFF  = 8'h00;
   localparam logic [7:0] CTRL_B_OFF  = 8'h04;
   localparam logic [7:0] CTRL_C_OFF  = 8'h08;
   localparam logic [7:0] CTRL_E_OFF  = 8'h0C;
   localparam logic [7:0] CTRL_F_OFF  = 8'h10;
   localparam logic [7:0] COMMAND_OFF = 8'h14;
   localparam logic [7:0] AMP_CTL_OFF = 8'h18;
   localparam logic [7:0] FLAGS_OFF   = 8'h1C;
   localparam logic [7:0] RESULT_OFF  = 8'h20;
   localparam logic [7:0] SAMPLE_OFF  = 8'h24;
   // Field positions
   localparam int ENABLE_BIT    = 0;
   localparam int STAY_WARM_BIT = 1;
   localparam int RESTART_BIT   = 0;
   localparam int ALIGN_BIT     = 1;
   localparam int START_BIT     = 0;
   localparam int EIGHT_BIT     = 1;
   localparam int TWO_INPUT_BIT = 2;
   localparam int AMP_EN_BIT    = 3;
   localparam int DONE_BIT      = 0;
   localparam int SINGLE_BIT    = 1;
   localparam int BUSY_BIT      = 2;
   localparam int AMP_LEN_LSB   = 4;
   // Values after reset
   localparam logic [7:0] AMP_CTL_RESET = 8'h21;
   localparam logic [7:0] TIMEBASE_RESET = 8'h01;
   // Conversion lengths after sampling, counted in half conversion clocks
   localparam logic [9:0] CONV12_HALF = 10'h01F;
   localparam logic [9:0] CONV8_HALF  = 10'h017;
   // Bus responses
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {ST_IDLE, ST_INIT, ST_ACQUIRE, ST_CONVERT} seq_state_type;

   typedef struct packed {
      logic two_input;
      logic eight_bit;
      logic msb_align;
   } format_cfg_type;
endpackage

// *** rtl/adc_result_format.sv ***
/*
 Turns the raw converter value into the sample and result words.
 Assumes the raw value is held stable while the caller captures the outputs.
*/
`timescale 1ns/1ps
module adc_result_format (
   input  wire logic                    aclk,
   input  wire logic                    aresetn,
   input  wire logic                    load,
   input  wire adc_pkg::format_cfg_type cfg,
   input  wire logic signed [13:0]      raw_code,
   output logic [15:0]                  sample_word,
   output logic [31:0]                  result_word
);
   import adc_pkg::*;

   logic signed [13:0] hi_lim;
   logic signed [13:0] lo_lim;
   logic signed [13:0] clipped;
   logic [15:0]        next_sample;
   logic               use_align;

   // Code range per input kind and width
   always_comb begin
      if (cfg.two_input) begin
         hi_lim = cfg.eight_bit ? 14'sd127 : 14'sd2047;
         lo_lim = cfg.eight_bit ? -14'sd128 : -14'sd2048;
      end else begin
         hi_lim = cfg.eight_bit ? 14'sd255 : 14'sd4095;
         lo_lim = 14'sd0;
      end
   end

   // Saturate, extend and align
   always_comb begin
      use_align = cfg.msb_align && !cfg.eight_bit;
      if (raw_code > hi_lim) begin
         clipped = hi_lim;
      end else if (raw_code < lo_lim) begin
         clipped = lo_lim;
      end else begin
         clipped = raw_code;
      end
      if (use_align) begin
         next_sample = {clipped[11:0], 4'h0};
      end else if (cfg.two_input) begin
         next_sample = {{2{clipped[13]}}, clipped};
      end else begin
         next_sample = {4'h0, clipped[11:0]};
      end
   end

   // Both words updated from the same value
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sample_word <= 16'h0000;
         result_word <= 32'h0000_0000;
      end else if (load) begin
         sample_word <= next_sample;
         result_word <= cfg.two_input ? {{16{next_sample[15]}}, next_sample}
                                      : {16'h0000, next_sample};
      end
   end
endmodule

// *** rtl/adc_single_conv.sv ***
/*
 Converter sequencer, clock divider, timebase and AXI4-Lite register file.
 Assumes the analog core presents its value on raw_code when conv_done pulses.
*/
`timescale 1ns/1ps
module adc_single_conv #(
   parameter int INIT_US = 60
) (
   input  wire logic               aclk,
   input  wire logic               aresetn,
   input  wire logic [7:0]         s_axi_awaddr,
   input  wire logic               s_axi_awvalid,
   output logic                    s_axi_awready,
   input  wire logic [31:0]        s_axi_wdata,
   input  wire logic [3:0]         s_axi_wstrb,
   input  wire logic               s_axi_wvalid,
   output logic                    s_axi_wready,
   output logic [1:0]              s_axi_bresp,
   output logic                    s_axi_bvalid,
   input  wire logic               s_axi_bready,
   input  wire logic [7:0]         s_axi_araddr,
   input  wire logic               s_axi_arvalid,
   output logic                    s_axi_arready,
   output logic [31:0]             s_axi_rdata,
   output logic [1:0]              s_axi_rresp,
   output logic                    s_axi_rvalid,
   input  wire logic               s_axi_rready,
   input  wire logic               start_trigger,
   input  wire logic signed [13:0] raw_code,
   output logic                    input_sampling,
   output logic                    amp_hold,
   output logic                    converting,
   output logic                    conv_done,
   output logic [1:0]              amp_current_sel
);
   import adc_pkg::*;

   logic            enable;
   logic            stay_warm;
   logic [2:0]      clock_divider_sel;
   logic [7:0]      timebase;
   logic [7:0]      acquire_length;
   logic            auto_restart;
   logic            msb_align;
   format_cfg_type  fmt_cfg;
   logic            amp_enable;
   logic [7:0]      amp_control_reg;
   logic [3:0]      amp_output_acquire_len;
   logic            conversion_done_flag;
   logic            single_done_flag;
   logic [15:0]     latest_sample_word;
   logic [31:0]     conversion_result_word;
   seq_state_type   state;
   logic [2:0]      div_cnt;
   logic            half_tick;
   logic [7:0]      us_cnt;
   logic            us_tick;
   logic [15:0]     init_cnt;
   logic            warm;
   logic [9:0]      phase_cnt;
   logic [9:0]      acq_half;
   logic [9:0]      conv_half;
   logic            aw_held;
   logic            w_held;
   logic [7:0]      aw_addr;
   logic [31:0]     w_data;
   logic            w_lane0;
   logic            wr_go;
   logic            rd_go;
   logic            start_req;
   logic            sw_start;
   logic            clr_done;
   logic            clr_single;

   assign amp_current_sel        = amp_control_reg[1:0];
   assign amp_output_acquire_len = amp_control_reg[AMP_LEN_LSB +: 4];
   assign wr_go = aw_held && w_held && !s_axi_bvalid;
   assign rd_go = s_axi_arvalid && s_axi_arready;
   assign sw_start = wr_go && w_lane0 && aw_addr == COMMAND_OFF && w_data[START_BIT];
   assign start_req = enable && (sw_start || start_trigger);

   // Sampling and converting lengths in half conversion clocks
   assign acq_half  = {1'b0, acquire_length, 1'b0} + (amp_enable ? 10'h002 : 10'h001);
   assign conv_half = (fmt_cfg.eight_bit ? CONV8_HALF : CONV12_HALF)
                      - (amp_enable ? 10'h002 : 10'h001);

   // Half-period enable of the conversion clock; divide ratio is 2*(sel+1)
   always_ff @(posedge aclk) begin
      if (!aresetn || state == ST_IDLE || state == ST_INIT) begin
         div_cnt <= 3'h0;
      end else if (div_cnt == clock_divider_sel) begin
         div_cnt <= 3'h0;
      end else begin
         div_cnt <= div_cnt + 3'h1;
      end
   end
   assign half_tick = state != ST_IDLE && state != ST_INIT && div_cnt == clock_divider_sel;

   // Microsecond timebase, independent of the conversion clock
   always_ff @(posedge aclk) begin
      if (!aresetn || state != ST_INIT) begin
         us_cnt <= 8'h00;
      end else if (us_cnt + 8'h01 >= timebase) begin
         us_cnt <= 8'h00;
      end else begin
         us_cnt <= us_cnt + 8'h01;
      end
   end
   assign us_tick = state == ST_INIT && us_cnt + 8'h01 >= timebase;

   // Initialization delay in microseconds
   always_ff @(posedge aclk) begin
      if (!aresetn || state != ST_INIT) begin
         init_cnt <= 16'h0000;
      end else if (us_tick) begin
         init_cnt <= init_cnt + 16'h0001;
      end
   end

   // Warm state remembered while enabled
   always_ff @(posedge aclk) begin
      if (!aresetn || !enable) begin
         warm <= 1'b0;
      end else if (state == ST_INIT && us_tick && init_cnt == 16'(INIT_US - 1)) begin
         warm <= 1'b1;
      end
   end

   // Conversion sequencer
   always_ff @(posedge aclk) begin
      if (!aresetn || !enable) begin
         state     <= ST_IDLE;
         phase_cnt <= 10'h000;
      end else begin
         unique case (state)
            ST_IDLE: begin
               phase_cnt <= 10'h000;
               if (start_req) begin
                  state <= (stay_warm && warm) ? ST_ACQUIRE : ST_INIT;
               end
            end
            ST_INIT: begin
               if (us_tick && init_cnt == 16'(INIT_US - 1)) begin
                  state <= ST_ACQUIRE;
               end
            end
            ST_ACQUIRE: begin
               if (half_tick) begin
                  if (phase_cnt == acq_half - 10'h001) begin
                     phase_cnt <= 10'h000;
                     state     <= ST_CONVERT;
                  end else begin
                     phase_cnt <= phase_cnt + 10'h001;
                  end
               end
            end
            ST_CONVERT: begin
               if (half_tick) begin
                  if (phase_cnt == conv_half - 10'h001) begin
                     phase_cnt <= 10'h000;
                     if (auto_restart) begin
                        state <= (stay_warm && warm) ? ST_ACQUIRE : ST_INIT;
                     end else begin
                        state <= ST_IDLE;
                     end
                  end else begin
                     phase_cnt <= phase_cnt + 10'h001;
                  end
               end
            end
         endcase
      end
   end

   // Front-end controls; the amplifier holds only while its output is acquired
   assign conv_done      = state == ST_CONVERT && half_tick && phase_cnt == conv_half - 10'h001;
   assign input_sampling = state == ST_ACQUIRE;
   assign converting     = state == ST_CONVERT;
   assign amp_hold       = amp_enable && state == ST_CONVERT
                           && phase_cnt < {5'h00, amp_output_acquire_len, 1'b0};

   adc_result_format u_format (
      .aclk        (aclk),
      .aresetn     (aresetn),
      .load        (conv_done),
      .cfg         (fmt_cfg),
      .raw_code    (raw_code),
      .sample_word (latest_sample_word),
      .result_word (conversion_result_word)
   );

   // Done flags; a new result wins over any clear in the same cycle
   assign clr_done   = (rd_go && s_axi_araddr == RESULT_OFF)
                       || (wr_go && w_lane0 && aw_addr == FLAGS_OFF && w_data[DONE_BIT]);
   assign clr_single = (rd_go && s_axi_araddr == SAMPLE_OFF)
                       || (wr_go && w_lane0 && aw_addr == FLAGS_OFF && w_data[SINGLE_BIT]);
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         conversion_done_flag <= 1'b0;
         single_done_flag     <= 1'b0;
      end else begin
         if (conv_done) begin
            conversion_done_flag <= 1'b1;
         end else if (clr_done) begin
            conversion_done_flag <= 1'b0;
         end
         if (conv_done) begin
            single_done_flag <= 1'b1;
         end else if (clr_single) begin
            single_done_flag <= 1'b0;
         end
      end
   end

   // Write address and data taken in either order
   assign s_axi_awready = !aw_held;
   assign s_axi_wready  = !w_held;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held <= 1'b0;
         w_held  <= 1'b0;
         aw_addr <= 8'h00;
         w_data  <= 32'h0000_0000;
         w_lane0 <= 1'b0;
      end else begin
         if (s_axi_awvalid && !aw_held) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end else if (wr_go) begin
            aw_held <= 1'b0;
         end
         if (s_axi_wvalid && !w_held) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_lane0 <= s_axi_wstrb[0];                                      // Strobe taken with data
         end else if (wr_go) begin
            w_held <= 1'b0;
         end
      end
   end

   // Write response
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= RESP_OKAY;
      end else if (wr_go) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= (aw_addr > SAMPLE_OFF || aw_addr[1:0] != 2'h0) ? RESP_SLVERR : RESP_OKAY;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // Control registers; only the low byte lane carries fields
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         enable            <= 1'b0;
         stay_warm         <= 1'b0;
         clock_divider_sel <= 3'h0;
         timebase          <= TIMEBASE_RESET;
         acquire_length    <= 8'h00;
         auto_restart      <= 1'b0;
         msb_align         <= 1'b0;
         fmt_cfg           <= '0;
         amp_enable        <= 1'b0;
         amp_control_reg   <= AMP_CTL_RESET;
      end else if (wr_go && w_lane0) begin
         unique case (aw_addr)
            CTRL_A_OFF: begin
               enable    <= w_data[ENABLE_BIT];
               stay_warm <= w_data[STAY_WARM_BIT];
            end
            CTRL_B_OFF: clock_divider_sel <= w_data[2:0];
            CTRL_C_OFF: timebase <= w_data[7:0];
            CTRL_E_OFF: acquire_length <= w_data[7:0];
            CTRL_F_OFF: begin
               auto_restart <= w_data[RESTART_BIT];
               msb_align    <= w_data[ALIGN_BIT];
            end
            COMMAND_OFF: begin
               if (state == ST_IDLE) begin
                  fmt_cfg.eight_bit <= w_data[EIGHT_BIT];
                  fmt_cfg.two_input <= w_data[TWO_INPUT_BIT];
                  amp_enable        <= w_data[AMP_EN_BIT];
               end
            end
            AMP_CTL_OFF: amp_control_reg <= w_data[7:0];
            default: ;
         endcase
      end else begin
         fmt_cfg.msb_align <= msb_align;
      end
   end

   // Read channel, one cycle after the address is taken
   assign s_axi_arready = !s_axi_rvalid;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= RESP_OKAY;
      end else if (rd_go) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp  <= RESP_OKAY;
         unique case (s_axi_araddr)
            CTRL_A_OFF:  s_axi_rdata <= {30'h0, stay_warm, enable};
            CTRL_B_OFF:  s_axi_rdata <= {29'h0, clock_divider_sel};
            CTRL_C_OFF:  s_axi_rdata <= {24'h0, timebase};
            CTRL_E_OFF:  s_axi_rdata <= {24'h0, acquire_length};
            CTRL_F_OFF:  s_axi_rdata <= {30'h0, msb_align, auto_restart};
            COMMAND_OFF: s_axi_rdata <= {28'h0, amp_enable, fmt_cfg.two_input,
                                         fmt_cfg.eight_bit, 1'b0};
            AMP_CTL_OFF: s_axi_rdata <= {24'h0, amp_control_reg};
            FLAGS_OFF:   s_axi_rdata <= {29'h0, state != ST_IDLE, single_done_flag,
                                         conversion_done_flag};
            RESULT_OFF:  s_axi_rdata <= conversion_result_word;
            SAMPLE_OFF:  s_axi_rdata <= {16'h0, latest_sample_word};
            default: begin
               s_axi_rdata <= 32'h0000_0000;
               s_axi_rresp <= RESP_SLVERR;
            end
         endcase
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // Checks
   property p_acquire_len;
      @(posedge aclk) disable iff (!aresetn)
      state == ST_ACQUIRE && half_tick && enable && phase_cnt == acq_half - 10'h001
      |=> state == ST_CONVERT && phase_cnt == 10'h000;
   endproperty
   a_acquire_len: assert property (p_acquire_len) else $error("sampling length wrong");

   property p_acquire_hold;
      @(posedge aclk) disable iff (!aresetn)
      state == ST_ACQUIRE && enable && !(half_tick && phase_cnt == acq_half - 10'h001)
      |=> state == ST_ACQUIRE;
   endproperty
   a_acquire_hold: assert property (p_acquire_hold) else $error("sampling ended early");

   property p_convert_len;
      @(posedge aclk) disable iff (!aresetn)
      state == ST_CONVERT && enable && !conv_done |=> state == ST_CONVERT;
   endproperty
   a_convert_len: assert property (p_convert_len) else $error("conversion ended early");

   property p_restart;
      @(posedge aclk) disable iff (!aresetn)
      conv_done && auto_restart && enable |=> state == ST_ACQUIRE || state == ST_INIT;
   endproperty
   a_restart: assert property (p_restart) else $error("no automatic restart");

   property p_flags;
      @(posedge aclk) disable iff (!aresetn)
      conv_done |=> conversion_done_flag && single_done_flag;
   endproperty
   a_flags: assert property (p_flags) else $error("done flags not set");

   property p_read_clear;
      @(posedge aclk) disable iff (!aresetn)
      rd_go && s_axi_araddr == RESULT_OFF && !conv_done |=> !conversion_done_flag;
   endproperty
   a_read_clear: assert property (p_read_clear) else $error("flag kept after read");

   property p_same_value;
      @(posedge aclk) disable iff (!aresetn)
      conv_done |=> conversion_result_word[15:0] == latest_sample_word;
   endproperty
   a_same_value: assert property (p_same_value) else $error("words differ");

   property p_upper_zero;
      @(posedge aclk) disable iff (!aresetn)
      conv_done && !fmt_cfg.two_input |=> conversion_result_word[31:16] == 16'h0000;
   endproperty
   a_upper_zero: assert property (p_upper_zero) else $error("upper bits not zero");

   property p_warm_skip;
      @(posedge aclk) disable iff (!aresetn)
      state == ST_IDLE && start_req && stay_warm && warm |=> state == ST_ACQUIRE;
   endproperty
   a_warm_skip: assert property (p_warm_skip) else $error("init repeated");

   c_done:    cover property (@(posedge aclk) conv_done);
   c_restart: cover property (@(posedge aclk) conv_done && auto_restart);
   c_amp:     cover property (@(posedge aclk) amp_hold);
   c_warm:    cover property (@(posedge aclk) state == ST_IDLE && start_req && warm);
endmodule

// *** bench/adc_front_model.sv ***
/* Analog front end: follows level while sampling, holds it while converting.
   Assumes raw_code is only taken in the conv_done cycle. */
`timescale 1ns/1ps
module adc_front_model (
   input  wire logic               aclk,
   input  wire logic               input_sampling,
   input  wire logic               converting,
   input  wire logic signed [13:0] level,
   output logic signed [13:0]      raw_code
);
   logic signed [13:0] held;
   // Track the input until sampling ends
   always_ff @(posedge aclk) begin
      if (input_sampling) begin
         held <= level;
      end
   end
   // Outside conversion the value is not valid, so show its inverse
   assign raw_code = converting ? held : ~held;
endmodule

// *** bench/adc_single_conv_tb_top.sv ***
/* Bench for the converter control: bus tasks and a table of format cases.
   Assumes a 250 MHz clock and INIT_US shortened to 2. */
`timescale 1ns/1ps
module adc_single_conv_tb_top;
   import adc_pkg::*;
   logic               aclk, awready, wready, bvalid, arready, rvalid;
   logic               input_sampling, amp_hold, converting, conv_done;
   logic               aresetn = 0, awvalid = 0, wvalid = 0, bready = 0;
   logic               arvalid = 0, rready = 0, start_trigger = 0;
   logic [7:0]         awaddr = 0, araddr = 0;
   logic [31:0]        wdata = 0, rdata, rd;
   logic [1:0]         bresp, rresp, resp, amp_current_sel;
   logic signed [13:0] level = 0, raw_code;
   int                 n_fail = 0, cmp_count = 0, cycles = 0, cnt = 0, len_seen = 0;
   int                 acq_seen = 0, hold_cnt = 0;
   // Per case: {align, amp, two_input, eight_bit}, input level, expected sample
   logic [3:0]         mode [10] = '{0, 0, 0, 2, 2, 8, 10, 1, 3, 4};
   logic signed [13:0] lvl [10] = '{14'h0ABC, 5000, -5, -3, 3000, 14'h123, -2, 300, -200, 14'h777};
   logic [15:0]        exps [10] = '{16'h0ABC, 16'h0FFF, 16'h0000, 16'hFFFD, 16'h07FF,
                                     16'h1230, 16'hFFE0, 16'h00FF, 16'hFF80, 16'h0777};

   adc_single_conv #(.INIT_US(2)) i_adc_single_conv (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .start_trigger(start_trigger), .raw_code(raw_code), .input_sampling(input_sampling),
      .amp_hold(amp_hold), .converting(converting), .conv_done(conv_done),
      .amp_current_sel(amp_current_sel));
   adc_front_model i_adc_front_model (.aclk(aclk), .input_sampling(input_sampling),
      .converting(converting), .level(level), .raw_code(raw_code));

   initial begin
      aclk = 0;
      forever #2 aclk = ~aclk;
   end
   // Conversion length monitor and hang cut-off
   always @(negedge aclk) begin
      cycles <= cycles + 1;
      cnt <= (input_sampling || converting) ? cnt + 1 : 0;
      if (conv_done) len_seen <= cnt + 1;
      if (input_sampling) acq_seen <= cnt + 1;
      hold_cnt <= input_sampling ? 0 : hold_cnt + amp_hold;
      if (cycles == 20000) begin
         n_fail = n_fail + 1;
         end_sim();
      end
   end

   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      cmp_count = cmp_count + 1;
      if (g !== e) begin
         n_fail = n_fail + 1;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      logic at, wt;
      at = 0;
      wt = 0;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1;
      wvalid <= 1;
      while (!(at && wt)) begin
         @(negedge aclk);
         if (awready) at = 1;
         if (wready) wt = 1;
         @(posedge aclk);
         if (at) awvalid <= 0;
         if (wt) wvalid <= 0;
      end
      bready <= 1;
      do @(negedge aclk); while (!bvalid);
      @(posedge aclk);
      bready <= 0;
   endtask
   task rd_reg(input logic [7:0] a);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1;
      do @(negedge aclk); while (!arready);
      @(posedge aclk);
      arvalid <= 0;
      rready <= 1;
      do @(negedge aclk); while (!rvalid);
      rd = rdata;
      resp = rresp;
      @(posedge aclk);
      rready <= 0;
   endtask
   task wait_done;
      do @(negedge aclk); while (!conv_done);
      @(posedge aclk);
   endtask
   task end_sim;
      $display("compares %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask

   // Main sequence
   initial begin
      repeat (5) @(posedge aclk);
      aresetn <= 1;
      rd_reg(AMP_CTL_OFF);
      chk("amp_ctl", 32'h21, rd);
      rd_reg(8'h40);
      chk("unmapped", RESP_SLVERR, resp);
      wr(CTRL_C_OFF, 32'h3);
      wr(CTRL_E_OFF, 32'h2);
      wr(AMP_CTL_OFF, 32'h22);
      chk("amp_sel", 32'h2, amp_current_sel);
      wr(CTRL_A_OFF, 32'h3);
      for (int i = 0; i < 10; i++) begin
         wr(CTRL_F_OFF, {30'h0, mode[i][3], 1'b0});
         wr(COMMAND_OFF, {28'h0, mode[i][2:0], 1'b0});
         level <= lvl[i];
         @(posedge aclk) start_trigger <= 1;
         @(posedge aclk) start_trigger <= 0;
         wait_done();
         rd_reg(FLAGS_OFF);
         chk("flags", 32'h3, rd & 32'h3);
         rd_reg(SAMPLE_OFF);
         chk("sample", exps[i], rd);
         rd_reg(RESULT_OFF);
         chk("result", mode[i][1] ? {{16{exps[i][15]}}, exps[i]} : exps[i], rd);
         rd_reg(FLAGS_OFF);
         chk("flags_clr", 32'h0, rd & 32'h3);
         chk("length", 4 + (mode[i][0] ? 23 : 31), len_seen);
         chk("sampling", 5 + mode[i][2], acq_seen);
         chk("amp_hold", mode[i][2] ? 4 : 0, hold_cnt);
         $display("test %0d done", i);
      end
      wr(CTRL_B_OFF, 32'h1);
      wr(COMMAND_OFF, 32'h1);
      wait_done();
      chk("div_length", 70, len_seen);
      $display("test divider done");
      wr(CTRL_F_OFF, 32'h1);
      wr(COMMAND_OFF, 32'h1);
      wait_done();
      rd_reg(RESULT_OFF);
      wait_done();
      rd_reg(FLAGS_OFF);
      chk("restart", 32'h1, rd & 32'h1);
      wr(CTRL_A_OFF, 32'h0);
      $display("test restart done");
      end_sim();
   end
endmodule
